// ===== include/sap_params.svh
`ifndef SAP_PARAMS_SVH
`define SAP_PARAMS_SVH

// Control byte field positions
`define SAP_ADDR_MSB 2
`define SAP_SGL_BIT 3
`define SAP_UNI_BIT 4
`define SAP_ACQMOD_BIT 5
`define SAP_PD0_BIT 6
`define SAP_PD1_BIT 7

// Clock-mode selections on the two top control bits
`define SAP_PD_EXT_CLK 2'h2
`define SAP_PD_INT_CLK 2'h3

// Timing counts in conversion-clock falling edges
`define SAP_CONV_TICKS 4'hd
`define SAP_CONV_LAST 4'hc
`define SAP_ACQ_TICKS 2'h3

// Internal oscillator period and system clock period
`define SAP_INT_CLK_NS 132
`define SAP_SYS_CLK_NS 10

// Reset value of the control byte, start value of the trial mask
`define SAP_RST_CFG 8'h00
`define SAP_SAR_MSB 12'h800

`endif

// ===== include/sap_pkg.sv
package sap_pkg;

    typedef enum logic [1:0] {
        SAP_IDLE,
        SAP_ACQ_EXT,
        SAP_ACQ_INT,
        SAP_CONV
    } sap_phase_t;

    typedef struct packed {
        sap_phase_t phase;
        logic [7:0] cfg;
        logic clk_int;
        logic [1:0] acq_cnt;
        logic [7:0] div_cnt;
        logic tick;
        logic wr_prev;
        logic rd_prev;
        logic clk_prev;
        logic done_n;
        logic rd_active;
        logic [11:0] result;
        logic [7:0] dout;
        logic dout_oe;
        logic done_oe;
        logic track;
        logic [2:0] pos_sel;
        logic [2:0] neg_sel;
        logic neg_com;
        logic hold_neg;
        logic [11:0] dac;
        logic start;
        logic abort;
    } sap_main_t;

    typedef struct packed {
        logic busy;
        logic [3:0] cnt;
        logic [11:0] code;
        logic [11:0] mask;
        logic done;
        logic hold_neg;
    } sap_eng_t;

endpackage : sap_pkg

// ===== include/sap_if.sv
`timescale 1ns/100ps
interface sap_if;
    logic start;
    logic abort;
    logic tick;
    logic cmp_keep;
    logic busy;
    logic hold_neg;
    logic done;
    logic [11:0] result;
    logic [11:0] dac_code;

    modport ctl (
        output start, abort, tick, cmp_keep,
        input busy, hold_neg, done, result, dac_code
    );
    modport eng (
        input start, abort, tick, cmp_keep,
        output busy, hold_neg, done, result, dac_code
    );
endinterface : sap_if

// ===== hdl/sap_sar_engine.sv
`timescale 1ns/100ps
`include "sap_params.svh"
module sap_sar_engine (
    input wire logic clk_sys,
    input wire logic rst_n,
    sap_if.eng bus
);
    sap_pkg::sap_eng_t s_ff;
    sap_pkg::sap_eng_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        if (bus.abort) begin
            nxt_s.busy = 1'b0;
            nxt_s.hold_neg = 1'b0;
        end
        if (bus.start) begin
            nxt_s.busy = 1'b1;
            nxt_s.cnt = 4'h0;
            nxt_s.code = 12'h000;
            nxt_s.mask = `SAP_SAR_MSB;
            nxt_s.hold_neg = 1'b0;
        end else if (s_ff.busy && bus.tick) begin
            if (s_ff.cnt == 4'h0) begin
                // First edge moves the hold node over and sets the MSB trial bit
                nxt_s.hold_neg = 1'b1;
                nxt_s.code = s_ff.mask;
            end else begin
                // Keep or drop the trial bit, then try the next one
                nxt_s.code = (bus.cmp_keep ? s_ff.code
                    : s_ff.code & ~s_ff.mask) | (s_ff.mask >> 1);
                nxt_s.mask = s_ff.mask >> 1;
                if (s_ff.cnt == `SAP_CONV_LAST) begin
                    nxt_s.busy = 1'b0;
                    nxt_s.done = 1'b1;
                    nxt_s.hold_neg = 1'b0;
                end
            end
            nxt_s.cnt = s_ff.cnt + 4'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign bus.busy = s_ff.busy;
    assign bus.hold_neg = s_ff.hold_neg;
    assign bus.done = s_ff.done;
    assign bus.result = s_ff.code;
    assign bus.dac_code = s_ff.code;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_conv_ticks: assert property (s_ff.done
        |-> s_ff.cnt == `SAP_CONV_TICKS)
        else $error("conversion did not take thirteen clock edges");
    a_hold_switch: assert property (s_ff.busy && bus.tick && s_ff.cnt == 4'h0
        && !bus.start && !bus.abort |=> s_ff.hold_neg)
        else $error("hold node not switched at conversion start");
endmodule : sap_sar_engine

// ===== hdl/sap_host_port.sv
`timescale 1ns/100ps
`include "sap_params.svh"
// Notes on behaviour
// - Done output goes low when result ready
// - Read fall with select low drives bus
// - Internal mode write captures byte, acquires, converts
// - External mode next write ends acquisition
// - Select high floats done and data
// - Twelve-bit result read as eight plus four
// - Single-ended: one channel against common pin
// - Differential: channel pair, positive side sampled
// - Hold capacitor tracks, then switch opens
// - Conversion flips hold, then successive approximation
// - High byte select picks upper nibble
// - Conversion takes thirteen clock edges
// - Done returns high on read or write
// - Write during conversion restarts acquisition
module sap_host_port #(
    parameter int NUM_CH = 8,
    parameter int INT_DIV = (`SAP_INT_CLK_NS + `SAP_SYS_CLK_NS / 2)
        / `SAP_SYS_CLK_NS
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic high_byte_select,
    input wire logic ext_clk,
    input wire logic [7:0] data_in,
    input wire logic cmp_keep,
    output logic [7:0] data_out,
    output logic data_oe,
    output logic done_n,
    output logic done_oe,
    output logic hold_capacitor_track,
    output logic hold_to_negative,
    output logic [2:0] pos_sel,
    output logic [2:0] neg_sel,
    output logic neg_is_common,
    output logic unipolar,
    output logic [11:0] dac_code
);
    localparam logic [2:0] CH_MASK = 3'(NUM_CH - 1);
    localparam logic [7:0] DIV_LAST = 8'(INT_DIV - 1);

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rst_sync_ff;
    logic rst_n;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync_ff <= 2'h0;
        end else begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_ff[1];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    sap_if eng_bus ();
    sap_pkg::sap_main_t s_ff;
    sap_pkg::sap_main_t nxt_s;
    logic wr_rise;
    logic rd_fall;
    logic [2:0] addr;

    assign wr_rise = ~s_ff.wr_prev & wr_n & ~cs_n;
    assign rd_fall = s_ff.rd_prev & ~rd_n & ~cs_n;
    assign addr = data_in[`SAP_ADDR_MSB:0] & CH_MASK;

    sap_sar_engine u_engine (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .bus(eng_bus)
    );

    assign eng_bus.start = s_ff.start;
    assign eng_bus.abort = s_ff.abort;
    assign eng_bus.tick = s_ff.tick;
    assign eng_bus.cmp_keep = cmp_keep;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        nxt_s.start = 1'b0;
        nxt_s.abort = 1'b0;
        nxt_s.tick = 1'b0;
        nxt_s.wr_prev = wr_n;
        nxt_s.rd_prev = rd_n;
        nxt_s.clk_prev = ext_clk;

        // Conversion clock: falling pin edge or divided system clock
        if (s_ff.clk_int) begin
            if (s_ff.div_cnt == DIV_LAST) begin
                nxt_s.div_cnt = 8'h00;
                nxt_s.tick = 1'b1;
            end else begin
                nxt_s.div_cnt = s_ff.div_cnt + 8'h01;
            end
        end else begin
            // A static pin in external mode never yields an edge
            nxt_s.tick = s_ff.clk_prev & ~ext_clk;
            nxt_s.div_cnt = 8'h00;
        end

        // A late abort ignores the engine's last done pulse
        if (eng_bus.done && !s_ff.abort) begin
            nxt_s.result = eng_bus.result;
            nxt_s.done_n = 1'b0;
            nxt_s.phase = sap_pkg::SAP_IDLE;
        end

        if (rd_fall) begin
            nxt_s.rd_active = 1'b1;
            // A finishing conversion beats the read that would clear it
            if (!eng_bus.done) begin
                nxt_s.done_n = 1'b1;
            end
        end
        if (rd_n || cs_n) begin
            nxt_s.rd_active = 1'b0;
        end

        if (s_ff.phase == sap_pkg::SAP_ACQ_INT && s_ff.tick) begin
            if (s_ff.acq_cnt == `SAP_ACQ_TICKS - 2'h1) begin
                nxt_s.track = 1'b0;
                nxt_s.start = 1'b1;
                nxt_s.phase = sap_pkg::SAP_CONV;
            end else begin
                nxt_s.acq_cnt = s_ff.acq_cnt + 2'h1;
            end
        end

        // Write handled last: it overrides the done, phase, track and start updates above
        if (wr_rise) begin
            nxt_s.cfg = data_in;
            nxt_s.done_n = 1'b1;
            nxt_s.abort = eng_bus.busy | s_ff.start;
            // A pending start must not survive a rewrite
            nxt_s.start = 1'b0;
            if (data_in[`SAP_PD1_BIT:`SAP_PD0_BIT] == `SAP_PD_INT_CLK) begin
                nxt_s.clk_int = 1'b1;
            end else if (data_in[`SAP_PD1_BIT:`SAP_PD0_BIT]
                == `SAP_PD_EXT_CLK) begin
                nxt_s.clk_int = 1'b0;
            end
            nxt_s.pos_sel = addr;
            if (data_in[`SAP_SGL_BIT]) begin
                nxt_s.neg_com = 1'b1;
                nxt_s.neg_sel = 3'h0;
            end else begin
                nxt_s.neg_com = 1'b0;
                nxt_s.neg_sel = addr ^ 3'h1;
            end
            if (s_ff.phase == sap_pkg::SAP_ACQ_EXT
                && !data_in[`SAP_ACQMOD_BIT]) begin
                nxt_s.track = 1'b0;
                nxt_s.start = 1'b1;
                nxt_s.abort = 1'b0;
                nxt_s.phase = sap_pkg::SAP_CONV;
            end else if (data_in[`SAP_ACQMOD_BIT]) begin
                nxt_s.track = 1'b1;
                nxt_s.phase = sap_pkg::SAP_ACQ_EXT;
            end else begin
                nxt_s.track = 1'b1;
                nxt_s.acq_cnt = 2'h0;
                nxt_s.phase = sap_pkg::SAP_ACQ_INT;
            end
        end

        // Pin images, registered so outputs come from flops
        if (high_byte_select) begin
            nxt_s.dout = {4'h0, nxt_s.result[11:8]};
        end else begin
            nxt_s.dout = nxt_s.result[7:0];
        end
        nxt_s.dout_oe = ~cs_n & nxt_s.rd_active;
        nxt_s.done_oe = ~cs_n;
        nxt_s.hold_neg = eng_bus.hold_neg;
        nxt_s.dac = eng_bus.dac_code;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_ff <= '0;
            s_ff.cfg <= `SAP_RST_CFG;
            s_ff.wr_prev <= 1'b1;
            s_ff.rd_prev <= 1'b1;
            s_ff.done_n <= 1'b1;
            s_ff.neg_com <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign data_out = s_ff.dout;
    assign data_oe = s_ff.dout_oe;
    assign done_n = s_ff.done_n;
    assign done_oe = s_ff.done_oe;
    assign hold_capacitor_track = s_ff.track;
    assign hold_to_negative = s_ff.hold_neg;
    assign pos_sel = s_ff.pos_sel;
    assign neg_sel = s_ff.neg_sel;
    assign neg_is_common = s_ff.neg_com;
    assign unipolar = s_ff.cfg[`SAP_UNI_BIT];
    assign dac_code = s_ff.dac;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence s_int_write;
        wr_rise && !data_in[`SAP_ACQMOD_BIT]
            && s_ff.phase != sap_pkg::SAP_ACQ_EXT;
    endsequence

    sequence s_ext_end;
        wr_rise && !data_in[`SAP_ACQMOD_BIT]
            && s_ff.phase == sap_pkg::SAP_ACQ_EXT;
    endsequence

    sequence s_late_abort;
        s_ff.abort && eng_bus.done;
    endsequence

    a_done_low: assert property (eng_bus.done && !wr_rise && !s_ff.abort
        |=> !done_n)
        else $error("done not asserted after conversion");
    a_read_drive: assert property (rd_fall |=> data_oe)
        else $error("read did not enable the data bus");
    a_int_acquire: assert property (s_int_write |=> hold_capacitor_track
        && s_ff.phase == sap_pkg::SAP_ACQ_INT)
        else $error("internal acquisition not started by write");
    a_ext_convert: assert property (s_ext_end |=> !hold_capacitor_track
        && s_ff.start ##1 eng_bus.busy)
        else $error("second write did not start conversion");
    a_float_cs: assert property (cs_n |=> !data_oe && !done_oe)
        else $error("outputs driven while deselected");
    a_byte_mux: assert property (data_out == ($past(high_byte_select)
        ? {4'h0, s_ff.result[11:8]} : s_ff.result[7:0]))
        else $error("wrong result byte on data bus");
    a_read_clear: assert property (rd_fall && !eng_bus.done |=> done_n)
        else $error("read did not release done");
    a_write_clear: assert property (wr_rise |=> done_n ##1 done_n)
        else $error("write did not release done");
    a_conv_abort: assert property (wr_rise && data_in[`SAP_ACQMOD_BIT]
        && s_ff.phase == sap_pkg::SAP_CONV
        |=> s_ff.abort ##1 !eng_bus.busy)
        else $error("write during conversion did not abort");
    a_int_hold: assert property (s_ff.phase == sap_pkg::SAP_ACQ_INT
        && s_ff.tick && s_ff.acq_cnt == 2'h2 && !wr_rise
        |=> !hold_capacitor_track && s_ff.start)
        else $error("hold switch not opened after three edges");

    // ------------------------------------------------------------
    // Checks on done, bus drive, start, selection, tracking, results and aborts
    // ------------------------------------------------------------
    a_done_stay: assert property (!done_n && !rd_fall && !wr_rise
        |=> !done_n)
        else $error("done released without read or write");
    a_done_drive: assert property (!cs_n |=> done_oe)
        else $error("done pin not driven while selected");
    a_read_release: assert property (rd_n || cs_n |=> !data_oe)
        else $error("data bus still driven after read ended");
    a_start_busy: assert property (s_ff.start |=> eng_bus.busy)
        else $error("conversion start not taken by the engine");
    a_unipolar_take: assert property (wr_rise
        |=> unipolar == $past(data_in[`SAP_UNI_BIT]))
        else $error("polarity bit not captured by write");
    a_result_take: assert property (eng_bus.done && !s_ff.abort
        |=> s_ff.result == $past(eng_bus.result))
        else $error("finished result not captured");
    a_single_ended: assert property (wr_rise && data_in[`SAP_SGL_BIT]
        |=> neg_is_common && pos_sel == $past(addr))
        else $error("single-ended write did not select common");
    a_diff_pair: assert property (wr_rise && !data_in[`SAP_SGL_BIT]
        |=> !neg_is_common && neg_sel == (pos_sel ^ 3'h1))
        else $error("differential write did not select a pair");
    a_track_end: assert property (s_ff.start |-> !hold_capacitor_track)
        else $error("start given while still tracking");
    a_ext_track: assert property (s_ff.phase == sap_pkg::SAP_ACQ_EXT
        |-> hold_capacitor_track)
        else $error("track switch open during external acquisition");
    a_conv_hold: assert property (s_ff.phase == sap_pkg::SAP_CONV
        |-> !hold_capacitor_track)
        else $error("track switch closed during conversion");
    a_abort_idle: assert property (s_ff.abort |=> !eng_bus.busy)
        else $error("abort did not stop the engine");
    a_abort_quiet: assert property (s_late_abort
        |=> s_ff.result == $past(s_ff.result)
        && s_ff.phase != sap_pkg::SAP_IDLE)
        else $error("abandoned conversion replaced the result");
endmodule : sap_host_port

// ===== verification/sap_afe_model.sv
`timescale 1ns/100ps
module sap_afe_model (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic track,
    input wire logic hold_neg,
    input wire logic [2:0] pos_sel,
    input wire logic [2:0] neg_sel,
    input wire logic neg_com,
    input wire logic [11:0] dac_code,
    input wire logic [11:0] ch_val [8],
    output logic cmp_keep
);
    logic track_ff;
    logic [11:0] held_ff;

    // Sample frozen when the track switch opens
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            track_ff <= 1'b0;
            held_ff <= 12'h000;
        end else begin
            track_ff <= track;
            if (track_ff && !track) begin
                held_ff <= neg_com ? ch_val[pos_sel] :
                    ch_val[pos_sel] - ch_val[neg_sel];
            end
        end
    end

    // No charge on the comparator until the hold cap flips
    assign cmp_keep = hold_neg && (dac_code <= held_ff);
endmodule : sap_afe_model

// ===== verification/sap_host_port_test.sv
`timescale 1ns/100ps
module sap_host_port_test;
    typedef struct packed {
        logic [7:0] cfg;
        logic [11:0] res;
    } sap_row_t;

    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic cs_n = 1'b1;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic high_byte_select = 1'b0;
    logic ext_clk = 1'b1;
    logic [7:0] data_in = 8'h00;
    logic cmp_keep;
    logic [7:0] data_out;
    logic data_oe, done_n, done_oe, track, hold_neg, neg_com, unipolar;
    logic [2:0] pos_sel, neg_sel;
    logic [11:0] dac_code;
    int failures = 0;
    int check_count = 0;
    int n;
    logic [11:0] ch_val [8] = '{12'h000, 12'hfff, 12'h5a5, 12'ha5a,
        12'h001, 12'h800, 12'h7ff, 12'h3c0};
    sap_row_t rows [10] = '{'{8'h88, 12'h000}, '{8'h89, 12'hfff},
        '{8'h8a, 12'h5a5}, '{8'h9b, 12'ha5a}, '{8'h8c, 12'h001},
        '{8'h8d, 12'h800}, '{8'h8e, 12'h7ff}, '{8'h8f, 12'h3c0},
        '{8'h83, 12'h4b5}, '{8'h85, 12'h7ff}};

    always #5 clk_sys = ~clk_sys;

    sap_host_port #(.NUM_CH(8), .INT_DIV(4)) i_sap_host_port (
        .clk_sys(clk_sys), .arst_n(arst_n), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .high_byte_select(high_byte_select),
        .ext_clk(ext_clk), .data_in(data_in), .cmp_keep(cmp_keep),
        .data_out(data_out), .data_oe(data_oe), .done_n(done_n),
        .done_oe(done_oe), .hold_capacitor_track(track),
        .hold_to_negative(hold_neg), .pos_sel(pos_sel),
        .neg_sel(neg_sel), .neg_is_common(neg_com),
        .unipolar(unipolar), .dac_code(dac_code));

    sap_afe_model i_sap_afe_model (
        .clk_sys(clk_sys), .arst_n(arst_n), .track(track),
        .hold_neg(hold_neg), .pos_sel(pos_sel), .neg_sel(neg_sel),
        .neg_com(neg_com), .dac_code(dac_code), .ch_val(ch_val),
        .cmp_keep(cmp_keep));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(input logic [11:0] seen, input logic [11:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task finish_test;
        $display("Counts: %0d checks, %0d failures", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test

    // Byte held steady until well after the strobe rises
    task wr(input logic [7:0] b);
        @(posedge clk_sys);
        data_in <= b;
        wr_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        wr_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : wr

    // Conversion clock idles high between bursts
    task tk(input int cnt);
        repeat (cnt) begin
            repeat (4) @(posedge clk_sys);
            ext_clk <= 1'b0;
            repeat (4) @(posedge clk_sys);
            ext_clk <= 1'b1;
        end
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : tk

    task rd(input logic hbs, input logic [7:0] exp);
        @(posedge clk_sys);
        high_byte_select <= hbs;
        rd_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(data_oe, 1);
        chk(data_out, exp);
        chk(done_n, 1);
        @(posedge clk_sys);
        rd_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(data_oe, 0);
    endtask : rd

    task conv16(input logic [11:0] res);
        tk(15);
        chk(track, 0);
        chk(hold_neg, 1);
        chk(done_n, 1);
        tk(1);
        chk(done_n, 0);
        chk(done_oe, 1);
        chk(dac_code, res);
        rd(1'b0, res[7:0]);
        rd(1'b1, {4'h0, res[11:8]});
    endtask : conv16

    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        finish_test();
    end

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(data_oe, 0);
        chk(done_oe, 0);
        chk(done_n, 1);
        chk(track, 0);
        $display("Test reset done");
        @(posedge clk_sys);
        cs_n <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].cfg);
            chk(track, 1);
            chk(pos_sel, rows[i].cfg[2:0]);
            chk(neg_com, rows[i].cfg[3]);
            if (!rows[i].cfg[3]) chk(neg_sel, rows[i].cfg[2:0] ^ 3'h1);
            chk(unipolar, rows[i].cfg[4]);
            conv16(rows[i].res);
        end
        $display("Test table done");
        // Internal oscillator, ext_clk parked high
        wr(8'hcd);
        for (n = 0; n < 300 && done_n !== 1'b0; n++) @(negedge clk_sys);
        chk(done_n, 0);
        rd(1'b1, 8'h08);
        $display("Test internal clock done");
        wr(8'ha9);
        tk(4);
        chk(track, 1);
        chk(done_n, 1);
        wr(8'h89);
        chk(track, 0);
        tk(12);
        chk(done_n, 1);
        tk(1);
        chk(done_n, 0);
        rd(1'b0, 8'hff);
        $display("Test external acquisition done");
        wr(8'h8a);
        tk(8);
        wr(8'h8e);
        chk(track, 1);
        chk(hold_neg, 0);
        conv16(12'h7ff);
        wr(8'h8c);
        tk(16);
        wr(8'h8c);
        chk(done_n, 1);
        conv16(12'h001);
        // Rewrite lands on the edge of the last conversion tick
        wr(8'h8d);
        tk(15);
        @(posedge clk_sys);
        data_in <= 8'h8e;
        wr_n <= 1'b0;
        ext_clk <= 1'b0;
        @(posedge clk_sys);
        wr_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        ext_clk <= 1'b1;
        @(negedge clk_sys);
        chk(done_n, 1);
        chk(track, 1);
        conv16(12'h7ff);
        // External acquisition requested during a conversion
        wr(8'h8a);
        tk(8);
        wr(8'h29);
        chk(track, 1);
        chk(hold_neg, 0);
        tk(2);
        wr(8'h09);
        chk(track, 0);
        tk(13);
        chk(done_n, 0);
        rd(1'b0, 8'hff);
        $display("Test abort and rewrite done");
        @(posedge clk_sys);
        cs_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rd_n <= 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(done_oe, 0);
        chk(data_oe, 0);
        $display("Test deselect done");
        finish_test();
    end
endmodule : sap_host_port_test
